// ==== common/ddr2_ext_consts.svh ====
// field positions, reset values and timing counts of the extended mode registers
`ifndef DDR2_EXT_CONSTS_SVH
`define DDR2_EXT_CONSTS_SVH

// ----------------------------------------------------------------------
// register width and reset values
// ----------------------------------------------------------------------
`define EXT_REG_WIDTH 13
`define EXT_SETTINGS_RESET 13'h0000
`define REFRESH_SETTINGS_RESET 13'h0000

// ----------------------------------------------------------------------
// bank address codes that select a register during a load
// ----------------------------------------------------------------------
`define SEL_EXTENDED_MODE 2'h1
`define SEL_REFRESH_RATE_MODE 2'h2

// ----------------------------------------------------------------------
// extended_mode_settings fields
// ----------------------------------------------------------------------
`define LOOP_DISABLE_BIT 0
`define DRIVE_STRENGTH_BIT 1
`define TERM_LOW_BIT 2
`define DELAY_LSB 3
`define DELAY_MSB 5
`define TERM_HIGH_BIT 6
`define CAL_LSB 7
`define CAL_MSB 9
`define COMPLEMENT_STROBE_OFF_BIT 10
`define REDUNDANT_STROBE_ON_BIT 11
`define OUTPUT_OFF_BIT 12

// ----------------------------------------------------------------------
// refresh_rate_mode_settings fields
// ----------------------------------------------------------------------
`define FAST_REFRESH_BIT 7

// ----------------------------------------------------------------------
// posted delay limits and delay-loop lock time
// ----------------------------------------------------------------------
`define POSTED_DELAY_MAX 3'h6
`define DELAY_STAGES 6
`define LOOP_LOCK_CLOCKS 200
`define LOOP_LOCK_COUNT 8'hc8

`endif

// ==== common/ddr2_ext_pkg.sv ====
// types shared by the extended mode register block
package ddr2_ext_pkg;

	// ------------------------------------------------------------------
	// device operating state, as supplied by the command sequencer
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ACTIVE = 3'h1,
		ST_ACTIVE_PD = 3'h2,
		ST_PRECHARGE_PD = 3'h3,
		ST_SELF_REFRESH = 3'h4,
		ST_OTHER = 3'h5
	} dev_state_t;

	// ------------------------------------------------------------------
	// effective on-die termination value
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		TERM_OFF = 2'h0,
		TERM_75 = 2'h1,
		TERM_150 = 2'h2,
		TERM_50 = 2'h3
	} term_value_t;

endpackage : ddr2_ext_pkg

// ==== rtl/posted_delay_line.sv ====
// holds an early read or write pulse for the posted delay
`timescale 1ns/1ps
`include "ddr2_ext_consts.svh"

module posted_delay_line (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic early_pulse,
	input wire logic [2:0] delay,
	output logic issue_r
);

	logic [`DELAY_STAGES-1:0] stage_r;
	logic tap_sel;

	// ------------------------------------------------------------------
	// shift chain, one stage per clock of delay
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `DELAY_STAGES; i = i + 1) begin : g_stage
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n)
					stage_r[i] <= 1'b0;
				else if (i == 0)
					stage_r[i] <= early_pulse;
				else
					stage_r[i] <= stage_r[(i == 0) ? 0 : i - 1];
			end
		end
	endgenerate

	// delays above the limit are clamped to the limit
	assign tap_sel = (delay == 3'h0) ? early_pulse :
		(delay > `POSTED_DELAY_MAX) ? stage_r[`DELAY_STAGES-1] :
		stage_r[delay - 3'h1];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			issue_r <= 1'b0;
		else
			issue_r <= tap_sel;
	end

endmodule : posted_delay_line

// ==== rtl/loop_lock_timer.sv ====
// counts the delay-loop lock time after a loop reset
`timescale 1ns/1ps
`include "ddr2_ext_consts.svh"

module loop_lock_timer (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic restart,
	input wire logic hold,
	output logic locked_r
);

	logic [7:0] count_r;
	logic [7:0] count_nxt;
	logic done;

	assign done = (count_r == `LOOP_LOCK_COUNT);
	assign count_nxt = (restart || hold) ? 8'h00 :
		done ? count_r : count_r + 8'h01;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_r <= 8'h00;
			locked_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			locked_r <= (count_nxt == `LOOP_LOCK_COUNT);
		end
	end

endmodule : loop_lock_timer

// ==== rtl/ddr2_ext_mode_regs.sv ====
// extended mode registers: load decode, storage and derived controls
// ----------------------------------------------------------------------
// Functional notes
// - settings persist until reloaded; reloading never touches the array
// - bit zero of the extended register enables or disables the loop
// - self refresh turns loop off; exit re-enables and resets it
// - drive bit zero gives full drive, one gives reduced drive
// - bit ten zero drives complement strobe; one makes strobe single-ended
// - complement redundant strobe only with bit eleven set, bit ten clear
// - by-eight with bit eleven: redundant strobe copies strobe on reads
// - bit twelve set disables all data and strobe outputs
// - termination 50, 75 or 150 ohms chosen by bits six and two
// - termination pin honoured only in active and power-down states
// - posted delay of 0 to 6 clocks from bits three to five
// - early read or write held for the posted delay before execution
// - read latency is delay plus column latency; write is one less
// - second register uses only bit seven, the fast refresh bit
// - load with bank bits 01 selects the extended register
// - load with bank bits 10 selects the refresh-rate register
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`include "ddr2_ext_consts.svh"

module ddr2_ext_mode_regs (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [2:0] bank_addr,
	input wire logic [12:0] addr,
	input wire logic [2:0] column_latency,
	input wire logic mode_loop_reset,
	input wire ddr2_ext_pkg::dev_state_t device_state,
	input wire logic term_pin,
	input wire logic wide8_config,
	input wire logic read_burst,
	input wire logic write_burst,
	input wire logic early_read,
	input wire logic early_write,
	output logic loop_enable_r,
	output logic loop_reset_r,
	output logic loop_locked_r,
	output logic drive_reduced_r,
	output logic data_out_enable_r,
	output logic strobe_out_enable_r,
	output logic complement_strobe_enable_r,
	output logic redundant_strobe_enable_r,
	output logic redundant_complement_enable_r,
	output ddr2_ext_pkg::term_value_t termination_value_r,
	output logic termination_on_r,
	output logic [2:0] posted_delay_r,
	output logic [3:0] read_latency_r,
	output logic [3:0] write_latency_r,
	output logic [2:0] driver_calibration_r,
	output logic fast_refresh_r,
	output logic read_issue_r,
	output logic write_issue_r
);

	// ------------------------------------------------------------------
	// load-mode command decode
	// ------------------------------------------------------------------
	function automatic logic load_selects(
		input logic cs_n,
		input logic ras_n,
		input logic cas_n,
		input logic we_n,
		input logic [1:0] bank,
		input logic [1:0] code
	);
		load_selects = !cs_n && !ras_n && !cas_n && !we_n && (bank == code);
	endfunction : load_selects

	logic load_extended;
	logic load_refresh;

	assign load_extended = load_selects(chip_select_n, row_strobe_n,
		col_strobe_n, write_enable_n, bank_addr[1:0],
		`SEL_EXTENDED_MODE);
	assign load_refresh = load_selects(chip_select_n, row_strobe_n,
		col_strobe_n, write_enable_n, bank_addr[1:0],
		`SEL_REFRESH_RATE_MODE);

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	logic [`EXT_REG_WIDTH-1:0] extended_mode_settings_r;
	logic [`EXT_REG_WIDTH-1:0] refresh_rate_mode_settings_r;
	logic [`EXT_REG_WIDTH-1:0] extended_mode_settings_nxt;
	logic [`EXT_REG_WIDTH-1:0] refresh_rate_mode_settings_nxt;

	// only the address lines up to twelve are stored; higher ones are ignored
	assign extended_mode_settings_nxt = load_extended ? addr :
		extended_mode_settings_r;
	assign refresh_rate_mode_settings_nxt = load_refresh ? addr :
		refresh_rate_mode_settings_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			extended_mode_settings_r <= `EXT_SETTINGS_RESET;
			refresh_rate_mode_settings_r <= `REFRESH_SETTINGS_RESET;
		end else begin
			extended_mode_settings_r <= extended_mode_settings_nxt;
			refresh_rate_mode_settings_r <= refresh_rate_mode_settings_nxt;
		end
	end

	// ------------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------------
	logic loop_disable_bit;
	logic drive_strength_bit;
	logic complement_strobe_off_bit;
	logic redundant_strobe_on_bit;
	logic output_off_bit;
	logic fast_refresh_bit;
	logic [1:0] term_code;
	logic [2:0] delay_field;
	logic [2:0] cal_field;

	assign loop_disable_bit =
		extended_mode_settings_r[`LOOP_DISABLE_BIT];
	assign drive_strength_bit =
		extended_mode_settings_r[`DRIVE_STRENGTH_BIT];
	assign complement_strobe_off_bit =
		extended_mode_settings_r[`COMPLEMENT_STROBE_OFF_BIT];
	assign redundant_strobe_on_bit =
		extended_mode_settings_r[`REDUNDANT_STROBE_ON_BIT];
	assign output_off_bit = extended_mode_settings_r[`OUTPUT_OFF_BIT];
	assign term_code = {extended_mode_settings_r[`TERM_HIGH_BIT],
		extended_mode_settings_r[`TERM_LOW_BIT]};
	assign delay_field =
		extended_mode_settings_r[`DELAY_MSB:`DELAY_LSB];
	assign cal_field = extended_mode_settings_r[`CAL_MSB:`CAL_LSB];
	// every other bit of the second register is kept but has no effect
	assign fast_refresh_bit =
		refresh_rate_mode_settings_r[`FAST_REFRESH_BIT];

	// ------------------------------------------------------------------
	// delay-locked loop control
	// ------------------------------------------------------------------
	logic in_self_refresh;
	logic in_self_refresh_r;
	logic self_refresh_exit;
	logic loop_enable_nxt;
	logic loop_reset_nxt;

	assign in_self_refresh = (device_state == ddr2_ext_pkg::ST_SELF_REFRESH);
	assign self_refresh_exit = in_self_refresh_r && !in_self_refresh;
	assign loop_enable_nxt = !loop_disable_bit && !in_self_refresh;
	// exit restarts the loop; a mode-register reset also restarts it
	assign loop_reset_nxt = (self_refresh_exit && !loop_disable_bit) ||
		(mode_loop_reset && !loop_disable_bit);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			in_self_refresh_r <= 1'b0;
			loop_enable_r <= 1'b0;
			loop_reset_r <= 1'b0;
		end else begin
			in_self_refresh_r <= in_self_refresh;
			loop_enable_r <= loop_enable_nxt;
			loop_reset_r <= loop_reset_nxt;
		end
	end

	// lock status: reads are safe once this rises
	loop_lock_timer u_lock (
		.clock(clock),
		.reset_n(reset_n),
		.restart(loop_reset_r),
		.hold(!loop_enable_r),
		.locked_r(loop_locked_r)
	);

	// ------------------------------------------------------------------
	// drive strength and calibration report
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			drive_reduced_r <= 1'b0;
			driver_calibration_r <= 3'h0;
			fast_refresh_r <= 1'b0;
		end else begin
			drive_reduced_r <= drive_strength_bit;
			driver_calibration_r <= cal_field;
			fast_refresh_r <= fast_refresh_bit;
		end
	end

	// ------------------------------------------------------------------
	// data and strobe output enables
	// ------------------------------------------------------------------
	logic outputs_allowed;
	logic data_out_nxt;
	logic comp_strobe_nxt;
	logic red_strobe_nxt;
	logic red_comp_nxt;

	assign outputs_allowed = !output_off_bit && read_burst;
	assign data_out_nxt = outputs_allowed;
	assign comp_strobe_nxt = outputs_allowed &&
		!complement_strobe_off_bit;
	// redundant strobe follows the read strobe; writes leave it ignored
	assign red_strobe_nxt = outputs_allowed && wide8_config &&
		redundant_strobe_on_bit;
	assign red_comp_nxt = red_strobe_nxt &&
		!complement_strobe_off_bit;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			data_out_enable_r <= 1'b0;
			strobe_out_enable_r <= 1'b0;
			complement_strobe_enable_r <= 1'b0;
			redundant_strobe_enable_r <= 1'b0;
			redundant_complement_enable_r <= 1'b0;
		end else begin
			data_out_enable_r <= data_out_nxt;
			strobe_out_enable_r <= data_out_nxt;
			complement_strobe_enable_r <= comp_strobe_nxt;
			redundant_strobe_enable_r <= red_strobe_nxt;
			redundant_complement_enable_r <= red_comp_nxt;
		end
	end

	// ------------------------------------------------------------------
	// on-die termination
	// ------------------------------------------------------------------
	ddr2_ext_pkg::term_value_t term_value;
	logic term_state_ok;
	logic term_on_nxt;

	assign term_value = ddr2_ext_pkg::term_value_t'(term_code);
	assign term_state_ok = (device_state == ddr2_ext_pkg::ST_ACTIVE) ||
		(device_state == ddr2_ext_pkg::ST_ACTIVE_PD) ||
		(device_state == ddr2_ext_pkg::ST_PRECHARGE_PD);
	assign term_on_nxt = term_pin && term_state_ok &&
		(term_value != ddr2_ext_pkg::TERM_OFF);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			termination_value_r <= ddr2_ext_pkg::TERM_OFF;
			termination_on_r <= 1'b0;
		end else begin
			termination_value_r <= term_value;
			termination_on_r <= term_on_nxt;
		end
	end

	// ------------------------------------------------------------------
	// posted delay and latencies
	// ------------------------------------------------------------------
	logic [2:0] delay_eff;
	logic [3:0] read_latency_nxt;
	logic [3:0] write_latency_nxt;

	// reserved code seven is treated as the largest legal delay
	assign delay_eff = (delay_field > `POSTED_DELAY_MAX) ?
		`POSTED_DELAY_MAX : delay_field;
	assign read_latency_nxt = {1'b0, delay_eff} +
		{1'b0, column_latency};
	assign write_latency_nxt = (read_latency_nxt == 4'h0) ? 4'h0 :
		read_latency_nxt - 4'h1;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			posted_delay_r <= 3'h0;
			read_latency_r <= 4'h0;
			write_latency_r <= 4'h0;
		end else begin
			posted_delay_r <= delay_eff;
			read_latency_r <= read_latency_nxt;
			write_latency_r <= write_latency_nxt;
		end
	end

	// ------------------------------------------------------------------
	// early command hold
	// ------------------------------------------------------------------
	posted_delay_line u_read_hold (
		.clock(clock),
		.reset_n(reset_n),
		.early_pulse(early_read),
		.delay(delay_eff),
		.issue_r(read_issue_r)
	);

	posted_delay_line u_write_hold (
		.clock(clock),
		.reset_n(reset_n),
		.early_pulse(early_write),
		.delay(delay_eff),
		.issue_r(write_issue_r)
	);

endmodule : ddr2_ext_mode_regs

// ==== testbench/ext_regs_monitor.sv ====
// checker for the extended mode register block
`timescale 1ns/1ps
module ext_regs_monitor (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [2:0] bank_addr,
	input wire logic [12:0] addr,
	input wire logic [2:0] column_latency,
	input wire ddr2_ext_pkg::dev_state_t device_state,
	input wire logic term_pin,
	input wire logic read_burst,
	input wire logic early_read,
	input wire logic loop_enable_r,
	input wire logic drive_reduced_r,
	input wire logic data_out_enable_r,
	input wire ddr2_ext_pkg::term_value_t termination_value_r,
	input wire logic termination_on_r,
	input wire logic [2:0] posted_delay_r,
	input wire logic [3:0] read_latency_r,
	input wire logic [3:0] write_latency_r,
	input wire logic fast_refresh_r,
	input wire logic read_issue_r
);
	// ------------------------------------------------------------------
	// shadow of the last loads
	// ------------------------------------------------------------------
	logic [12:0] ext_r;
	logic [12:0] rate_r;
	logic [2:0] quiet_r;
	logic [2:0] quiet_nxt;
	logic load_any;
	logic settled;
	logic term_state;
	logic [2:0] delay_exp;
	assign load_any = ~(chip_select_n | row_strobe_n | col_strobe_n
		| write_enable_n) & (bank_addr[1] ^ bank_addr[0]);
	assign quiet_nxt = load_any ? 3'h0 :
		(quiet_r == 3'h7 ? quiet_r : quiet_r + 3'h1);
	assign settled = quiet_r > 3'h2;
	assign delay_exp = (ext_r[5:3] == 3'h7) ? 3'h6 : ext_r[5:3];
	assign term_state = device_state inside {ddr2_ext_pkg::ST_ACTIVE,
		ddr2_ext_pkg::ST_ACTIVE_PD, ddr2_ext_pkg::ST_PRECHARGE_PD};
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ext_r <= 13'h0000;
			rate_r <= 13'h0000;
			quiet_r <= 3'h0;
		end else begin
			quiet_r <= quiet_nxt;
			if (load_any && bank_addr[0])
				ext_r <= addr;
			if (load_any && bank_addr[1])
				rate_r <= addr;
		end
	end
	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence cl_steady;
		$stable(column_latency) [*3];
	endsequence
	sequence rb_steady;
		$stable(read_burst) [*3];
	endsequence
	sequence st_steady;
		$stable(device_state) [*3];
	endsequence
	sequence pins_steady;
		($stable(term_pin) && $stable(device_state)) [*3];
	endsequence
	a_drive_bit_held: assert property (
		settled |-> drive_reduced_r == ext_r[1])
		else $error("drive strength differs from stored bit");
	a_term_code_map: assert property (
		settled |-> termination_value_r == {ext_r[6], ext_r[2]})
		else $error("termination value wrong");
	a_latency_sum: assert property (
		cl_steady ##0 settled |-> posted_delay_r == delay_exp
		&& read_latency_r == delay_exp + column_latency)
		else $error("posted delay or read latency wrong");
	a_write_one_less: assert property (
		cl_steady ##0 (settled && read_latency_r != 4'h0)
		|-> write_latency_r == read_latency_r - 4'h1)
		else $error("write latency not one below read latency");
	a_output_off_gate: assert property (
		rb_steady ##0 settled
		|-> data_out_enable_r == (read_burst & ~ext_r[12]))
		else $error("data output enable wrong");
	a_term_pin_gate: assert property (
		pins_steady ##0 settled |-> termination_on_r
		== (term_pin && (ext_r[6] || ext_r[2]) && term_state))
		else $error("termination switching wrong");
	a_refresh_bit_only: assert property (
		settled |-> fast_refresh_r == rate_r[7])
		else $error("fast refresh differs from stored bit");
	a_loop_enable_bit: assert property (
		st_steady ##0 settled |-> loop_enable_r == (!ext_r[0]
		&& device_state != ddr2_ext_pkg::ST_SELF_REFRESH))
		else $error("loop enable wrong");
	a_issue_after_delay: assert property (
		early_read && settled && posted_delay_r == 3'h2
		|-> ##3 read_issue_r)
		else $error("read not issued after posted delay");
endmodule : ext_regs_monitor

// ==== testbench/mode_loader.sv ====
// controller model issuing load-mode commands
`timescale 1ns/1ps
module mode_loader #(
	parameter int MODE_LOAD_WAIT = 2
) (
	input wire logic clock,
	output logic chip_select_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_enable_n,
	output logic [2:0] bank_addr,
	output logic [12:0] addr
);
	initial begin
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
		bank_addr = 3'h0;
		addr = 13'h0000;
	end
	// bank bit two zero while a command is driven; released lines show inverted values
	task automatic load(input logic [1:0] sel, input logic [12:0] word);
		@(posedge clock);
		#1;
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'h0;
		bank_addr = {1'b0, sel};
		addr = word;
		@(posedge clock);
		#1;
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
		bank_addr = ~bank_addr;
		addr = ~addr;
		repeat (MODE_LOAD_WAIT) @(posedge clock);
	endtask : load
endmodule : mode_loader

// ==== testbench/test_ddr2_ext_mode_regs.sv ====
// self-checking bench for the extended mode register block
`timescale 1ns/1ps
module test_ddr2_ext_mode_regs;
	logic clock, reset_n, mode_loop_reset, term_pin, wide8_config;
	logic read_burst, write_burst, early_read, early_write;
	logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
	logic [2:0] bank_addr, column_latency;
	logic [2:0] posted_delay_r, driver_calibration_r;
	logic [12:0] addr, w;
	ddr2_ext_pkg::dev_state_t device_state;
	ddr2_ext_pkg::term_value_t termination_value_r;
	logic loop_enable_r, loop_reset_r, loop_locked_r, drive_reduced_r;
	logic data_out_enable_r, complement_strobe_enable_r, termination_on_r;
	logic strobe_out_enable_r;
	logic redundant_strobe_enable_r, redundant_complement_enable_r;
	logic fast_refresh_r, read_issue_r, write_issue_r;
	logic [3:0] read_latency_r, write_latency_r;
	logic [15:0] cyc, exp_rd[$], exp_wr[$];
	logic [31:0] rnd;
	int n_fail, comparisons, n;
	int seed = 32'hc4e8;

	mode_loader u_ctrl (.clock, .chip_select_n, .row_strobe_n,
		.col_strobe_n, .write_enable_n, .bank_addr, .addr);
	ddr2_ext_mode_regs u_dut (
		.clock, .reset_n, .chip_select_n, .row_strobe_n, .col_strobe_n,
		.write_enable_n, .bank_addr, .addr, .column_latency, .mode_loop_reset,
		.device_state, .term_pin, .wide8_config, .read_burst, .write_burst,
		.early_read, .early_write, .loop_enable_r, .loop_reset_r,
		.loop_locked_r, .drive_reduced_r, .data_out_enable_r,
		.strobe_out_enable_r, .complement_strobe_enable_r,
		.redundant_strobe_enable_r, .redundant_complement_enable_r,
		.termination_value_r, .termination_on_r, .posted_delay_r,
		.read_latency_r, .write_latency_r, .driver_calibration_r,
		.fast_refresh_r, .read_issue_r, .write_issue_r
	);

	task automatic check(input string what, input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : tick

	task automatic close_out();
		if (n_fail == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic check_ext(input logic [12:0] x);
		logic [2:0] d;
		logic on;
		d = (x[5:3] == 3'h7) ? 3'h6 : x[5:3];
		on = read_burst & ~x[12];
		tick(3);
		check("drive", drive_reduced_r, x[1]);
		check("loop", loop_enable_r, !x[0]);
		check("term", termination_value_r, {x[6], x[2]});
		check("delay", posted_delay_r, d);
		check("rd lat", read_latency_r, d + column_latency);
		check("wr lat", write_latency_r, d + column_latency - 1);
		check("cal", driver_calibration_r, x[9:7]);
		check("data en", data_out_enable_r, on);
		check("strobe en", strobe_out_enable_r, on);
		check("compl", complement_strobe_enable_r, on & ~x[10]);
		on = on & wide8_config & x[11];
		check("rdnt", redundant_strobe_enable_r, on);
		check("rdnt c", redundant_complement_enable_r, on & ~x[10]);
	endtask : check_ext

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// issue pulses matched against noted times
	// ------------------------------------------------------------------
	always @(posedge clock) begin
		cyc = cyc + 16'h1;
		if (read_issue_r === 1'b1)
			check("rd issue", cyc,
				exp_rd.size() ? exp_rd.pop_front() : 16'h0000);
		if (write_issue_r === 1'b1)
			check("wr issue", cyc,
				exp_wr.size() ? exp_wr.pop_front() : 16'h0000);
	end

	initial begin
		#200000;
		n_fail++;
		close_out();
	end

	initial begin
		reset_n = 1'b0;
		cyc = 16'h0000;
		{mode_loop_reset, term_pin, early_read, early_write} = 4'h0;
		{wide8_config, read_burst, write_burst} = 3'h7;
		column_latency = 3'h3;
		device_state = ddr2_ext_pkg::ST_ACTIVE;
		tick(10);
		reset_n = 1'b1;
		tick(1);
		check("loop rst", loop_enable_r, 1'b1);
		check("term rst", termination_value_r, 2'h0);
		for (int i = 0; i < 14; i++) begin
			rnd = $random(seed);
			w = rnd[12:0];
			w[5:3] = 3'(i % 8);
			w[6] = i[1];
			w[2] = i[0];
			w[9:7] = {3{i[2]}};
			{wide8_config, read_burst, write_burst} = rnd[15:13];
			column_latency = 3'(3 + i % 5);
			u_ctrl.load(2'h1, w);
			check_ext(w);
		end
		w = 13'h0842;
		u_ctrl.load(2'h1, 13'h1fff);
		u_ctrl.load(2'h1, w);
		u_ctrl.load(2'h0, 13'h1fff);
		u_ctrl.load(2'h3, 13'h1fff);
		u_ctrl.load(2'h2, 13'h1fff);
		check_ext(w);
		check("fast", fast_refresh_r, 1'b1);
		u_ctrl.load(2'h2, 13'h1f7f);
		tick(3);
		check("fast", fast_refresh_r, 1'b0);
		u_ctrl.load(2'h1, 13'h0004);
		tick(8);
		for (int s = 0; s < 6; s++) begin
			device_state = ddr2_ext_pkg::dev_state_t'(s);
			term_pin = (s != 4);
			tick(3);
			check("term on", termination_on_r, s inside {[1:3]});
		end
		term_pin = 1'b0;
		device_state = ddr2_ext_pkg::ST_SELF_REFRESH;
		tick(3);
		check("loop off", loop_enable_r, 1'b0);
		device_state = ddr2_ext_pkg::ST_IDLE;
		n = 0;
		while (loop_reset_r !== 1'b1 && n < 4) begin
			tick(1);
			n++;
		end
		check("loop reset", loop_reset_r, 1'b1);
		tick(150);
		check("lock early", loop_locked_r, 1'b0);
		tick(60);
		check("lock", loop_locked_r, 1'b1);
		mode_loop_reset = 1'b1;
		tick(1);
		mode_loop_reset = 1'b0;
		tick(5);
		check("relock", loop_locked_r, 1'b0);
		for (int d = 0; d < 7; d++) begin
			u_ctrl.load(2'h1, {7'h00, d[2:0], 3'h0});
			tick(4);
			early_read = 1'b1;
			exp_rd.push_back(cyc + 16'(d + 2));
			tick(1);
			early_write = 1'b1;
			exp_rd.push_back(cyc + 16'(d + 2));
			exp_wr.push_back(cyc + 16'(d + 2));
			tick(1);
			{early_read, early_write} = 2'h0;
			tick(10);
		end
		check("left", 16'(exp_rd.size() + exp_wr.size()), 16'h0);
		u_ctrl.load(2'h1, 13'h0002);
		tick(3);
		check("drive", drive_reduced_r, 1'b1);
		reset_n = 1'b0;
		#2;
		check("drive rst", drive_reduced_r, 1'b0);
		tick(2);
		reset_n = 1'b1;
		tick(2);
		close_out();
	end
endmodule : test_ddr2_ext_mode_regs

bind ddr2_ext_mode_regs ext_regs_monitor u_mon (.clock, .reset_n,
	.chip_select_n, .row_strobe_n, .col_strobe_n, .write_enable_n,
	.bank_addr, .addr, .column_latency, .device_state, .term_pin,
	.read_burst, .early_read, .loop_enable_r, .drive_reduced_r,
	.data_out_enable_r, .termination_value_r, .termination_on_r,
	.posted_delay_r, .read_latency_r, .write_latency_r, .fast_refresh_r,
	.read_issue_r);
